// File: frit_consts.svh
// constants for the free-run interval timer: register map, fields, resets
// assumes inclusion by bare name from the package and design files
`ifndef FRIT_CONSTS_SVH
`define FRIT_CONSTS_SVH

`define FRIT_ADDR_W          4
`define FRIT_OFF_CTRL0       4'h0
`define FRIT_OFF_CTRL1       4'h1
`define FRIT_OFF_OUTMODE     4'h2
`define FRIT_OFF_CMP         4'h3
`define FRIT_OFF_COUNT       4'h4
`define FRIT_CTRL0_RST       8'h00
`define FRIT_CTRL1_RST       8'h00
`define FRIT_OUTMODE_RST     8'h00
`define FRIT_CMP_RST         8'hff
`define FRIT_FSEL_FREERUN    4'h2
`define FRIT_C1_RUN          7
`define FRIT_C1_IE           5
`define FRIT_C1_IR           4
`define FRIT_C1_IF           2
`define FRIT_OM_LVL0         6
`define FRIT_CSEL_LSB        4
`define FRIT_NUM_CSEL        8

`endif

// File: frit_pkg.sv
// types shared by the free-run interval timer files
// assumes frit_consts.svh on the include path
`include "frit_consts.svh"
package frit_pkg;
    typedef logic [7:0] frit_byte_t;
    typedef enum logic [1:0] {
        FRIT_IDLE = 2'b01,
        FRIT_RUN  = 2'b10
    } frit_state_e;
endpackage : frit_pkg

// File: frit_clkdiv.sv
// count clock prescaler: one-cycle enable at 1/2^(sel+1) of clk_i
// assumes a single clock domain; restart aligns the prescaler phase
module frit_clkdiv
    import frit_pkg::*;
#(
    parameter int unsigned DIV_W = 8
) (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       restart_i,
    input  wire logic [2:0] sel_i,
    output logic            tick_o
);
    logic [DIV_W-1:0] div_r;
    logic [DIV_W-1:0] mask;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_r <= '0;
        end else if (restart_i) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    always_comb begin
        mask = DIV_W'((1 << (sel_i + 1)) - 1);
    end

    assign tick_o = !restart_i && ((div_r & mask) == mask);
endmodule : frit_clkdiv

// File: frit_timer.sv
// free-run interval timer channel with plain register port
// assumes software on clk_i; count clock derived from clk_i by a prescaler
//
// Function
// - run request clears counter then counts count-clock edges
// - match toggles output and sets flag, no stop
// - counter wraps from all ones to zero
// - compare latch loaded at start and every match
// - stopped timer holds last output level until an OUTMODE write sets it
`include "frit_consts.svh"
module frit_timer
    import frit_pkg::*;
#(
    parameter int unsigned CNT_W = 8
) (
    input  wire logic                    clk_i,
    input  wire logic                    nrst_i,
    input  wire logic [`FRIT_ADDR_W-1:0] addr_i,
    input  wire logic [7:0]              wdata_i,
    input  wire logic                    wr_i,
    input  wire logic                    rd_i,
    output logic      [7:0]              rdata_o,
    output logic                         irq_o,
    output logic                         channel0_output_level_o
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    frit_byte_t       ctrl0_r;
    logic             run_r;
    logic             ie_r;
    logic             flag_r;
    logic             level_r;
    frit_byte_t       cmp_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] latch_r;
    frit_state_e      state_r;
    logic             tick;
    logic             start;
    logic             match;
    logic             wr_c1;
    logic             freerun;
    logic             wr_om;
    logic             stop_req;
    logic             ie_set;

    assign wr_c1    = wr_i && addr_i == `FRIT_OFF_CTRL1;
    assign wr_om    = wr_i && addr_i == `FRIT_OFF_OUTMODE;
    assign freerun  = ctrl0_r[3:0] == `FRIT_FSEL_FREERUN;
    // a run request under any other function is ignored, so nothing restarts
    assign start    = wr_c1 && wdata_i[`FRIT_C1_RUN] && !run_r && freerun;
    assign stop_req = wr_c1 && !wdata_i[`FRIT_C1_RUN];
    // enable write, only watched by the interrupt check
    assign ie_set   = wr_c1 && wdata_i[`FRIT_C1_IE];

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl0_r <= `FRIT_CTRL0_RST;
            cmp_r   <= `FRIT_CMP_RST;
        end else if (wr_i && addr_i == `FRIT_OFF_CTRL0) begin
            ctrl0_r <= wdata_i;
        end else if (wr_i && addr_i == `FRIT_OFF_CMP) begin
            cmp_r   <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            run_r <= 1'b0;
            ie_r  <= 1'b0;
        end else if (wr_c1) begin
            run_r <= wdata_i[`FRIT_C1_RUN] && freerun;
            ie_r  <= wdata_i[`FRIT_C1_IE];
        end
    end

    a_run_refused: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (wr_c1 && !freerun && !run_r) |=> !run_r && state_r == FRIT_IDLE)
        else $error("run accepted outside free-run function");

    // ----------------------------------------------------------------
    // count clock and state
    // ----------------------------------------------------------------
    frit_clkdiv #(.DIV_W(8)) u_div (
        .clk_i     (clk_i),
        .nrst_i    (nrst_i),
        .restart_i (start),
        .sel_i     (ctrl0_r[`FRIT_CSEL_LSB +: 3]),
        .tick_o    (tick)
    );

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_r <= FRIT_IDLE;
        end else begin
            case (state_r)
                FRIT_IDLE: begin
                    if (start) state_r <= FRIT_RUN;
                end
                FRIT_RUN: begin
                    if (stop_req) state_r <= FRIT_IDLE;
                end
                default: state_r <= FRIT_IDLE;
            endcase
        end
    end

    assign match = state_r == FRIT_RUN && tick && cnt_r == latch_r;

    a_stop_state: assert property (@(posedge clk_i) disable iff (!nrst_i)
        stop_req |=> state_r == FRIT_IDLE && !run_r)
        else $error("timer still running after stop");

    // ----------------------------------------------------------------
    // counter and compare latch
    // ----------------------------------------------------------------
    // counter cleared on start, wraps naturally past all ones
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_r <= '0;
        end else if (start) begin
            cnt_r <= '0;
        end else if (state_r == FRIT_RUN && tick) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    a_start_clears: assert property (@(posedge clk_i) disable iff (!nrst_i)
        start |=> cnt_r == '0)
        else $error("counter not cleared at start");
    a_count_step: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (state_r == FRIT_RUN && tick) |=> cnt_r == $past(cnt_r) + 1'b1)
        else $error("counter missed a count clock");
    a_count_wrap: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (state_r == FRIT_RUN && tick && !start && cnt_r == '1) |=> cnt_r == '0)
        else $error("counter failed to wrap");
    a_idle_count: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (state_r == FRIT_IDLE && !start) |=> $stable(cnt_r))
        else $error("counter moved while stopped");

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            latch_r <= '0;
        end else if (start || match) begin
            latch_r <= CNT_W'(cmp_r);
        end
    end

    a_latch_load: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (start || match) |=> latch_r == $past(cmp_r))
        else $error("compare latch not loaded");

    // ----------------------------------------------------------------
    // output level and match flag
    // ----------------------------------------------------------------

    // output holds when idle unless OUTMODE is written, since it only changes on match or an OUTMODE write
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            level_r <= 1'b0;
        end else if (match) begin
            level_r <= !level_r;
        end else if (wr_om) begin
            level_r <= wdata_i[`FRIT_OM_LVL0];
        end
    end

    a_match_toggle: assert property (@(posedge clk_i) disable iff (!nrst_i)
        match |=> level_r != $past(level_r))
        else $error("output not toggled on match");
    a_level_quiet: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (!match && !wr_om) |=> $stable(level_r))
        else $error("output moved without a match");
    a_idle_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (state_r == FRIT_IDLE && !wr_om) |=> $stable(level_r))
        else $error("output moved while stopped");

    // set wins over software clear (write 0 to flag bit)
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flag_r <= 1'b0;
        end else if (match) begin
            flag_r <= 1'b1;
        end else if (wr_c1 && !wdata_i[`FRIT_C1_IF]) begin
            flag_r <= 1'b0;
        end
    end

    // a stop written in the match cycle may legally end the run
    a_match_flag: assert property (@(posedge clk_i) disable iff (!nrst_i)
        match |=> flag_r && (state_r == FRIT_RUN || $past(stop_req)))
        else $error("flag or run lost on match");
    a_flag_sticky: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (flag_r && !wr_c1) |=> flag_r)
        else $error("flag dropped without clear");
    a_flag_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (wr_c1 && !wdata_i[`FRIT_C1_IF] && !match) |=> !flag_r)
        else $error("flag not cleared by software");

    assign irq_o = flag_r && ie_r;
    assign channel0_output_level_o = level_r;

    // request may only rise from a new match or a fresh enable
    a_irq_gate: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(irq_o) |-> $past(match) || $past(ie_set))
        else $error("interrupt raised without cause");

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                `FRIT_OFF_CTRL0:   rdata_o <= ctrl0_r;
                `FRIT_OFF_CTRL1:   rdata_o <= {run_r, 1'b0, ie_r, irq_o, 1'b0, flag_r, 2'b00};
                `FRIT_OFF_OUTMODE: rdata_o <= {1'b0, level_r, 6'h00};
                `FRIT_OFF_CMP:     rdata_o <= cmp_r;
                `FRIT_OFF_COUNT:   rdata_o <= 8'(cnt_r);
                default:           rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

endmodule : frit_timer

// File: frit_timer_tb.sv
// self-checking bench for the free-run interval timer channel
// assumes frit_pkg is compiled before this file; constants header included here
`include "frit_consts.svh"
module frit_timer_tb
    import frit_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i, nrst_i, wr_i, rd_i, irq_o, lvl_o;
    logic [3:0]  addr_i;
    frit_byte_t  wdata_i, rdata_o, v, a, b;
    logic [31:0] seed;
    int          error_cnt, comparisons;

    frit_timer dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .channel0_output_level_o(lvl_o));

    // ----------------------------------------
    // bus tasks and checking
    // ----------------------------------------
    function automatic frit_byte_t rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    task automatic chk(string n, frit_byte_t s, frit_byte_t e);
        comparisons++;
        if (s !== e) begin
            error_cnt++;
            $display("ERROR %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic wr(logic [3:0] ad, frit_byte_t d);
        @(posedge clk_i);
        addr_i  <= ad;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask : wr
    task automatic rd(logic [3:0] ad, output frit_byte_t d);
        @(posedge clk_i);
        addr_i <= ad;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1 d = rdata_o;
    endtask : rd
    // waits for a match, then checks where the counter stood
    task automatic at_match(frit_byte_t m, logic l);
        for (int i = 0; i < 1200 && irq_o !== 1'b1; i++) @(posedge clk_i);
        rd(`FRIT_OFF_COUNT, v);
        chk("match_cnt", {7'h0, (v - m) < 8}, 8'h01);
        chk("level", {7'h0, lvl_o}, {7'h0, l});
    endtask : at_match
    task complete_run;
        if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        #1000000;
        error_cnt++;
        complete_run();
    end

    initial begin
        {nrst_i, wr_i, rd_i, addr_i, wdata_i} = '0;
        seed = 32'h05b95f3d;
        error_cnt = 0;
        comparisons = 0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd(`FRIT_OFF_CTRL0, v);
        chk("ctrl0", v, `FRIT_CTRL0_RST);
        rd(`FRIT_OFF_CTRL1, v);
        chk("ctrl1", v, `FRIT_CTRL1_RST);
        rd(`FRIT_OFF_OUTMODE, v);
        chk("outmode", v, `FRIT_OUTMODE_RST);
        rd(`FRIT_OFF_CMP, v);
        chk("cmp", v, `FRIT_CMP_RST);
        rd(4'hf, v);
        chk("unmapped", v, 8'h00);
        for (int f = 0; f < 16; f++) if (f != 2) begin
            wr(`FRIT_OFF_CTRL0, f[7:0]);
            wr(`FRIT_OFF_CTRL1, 8'h80);
            rd(`FRIT_OFF_CTRL1, v);
            chk("run_refused", {7'h0, v[7]}, 8'h00);
        end
        // each count clock select: restart from zero, 4 ticks per 4 periods
        for (int s = 0; s < 8; s++) begin
            wr(`FRIT_OFF_CTRL1, 8'h00);
            wr(`FRIT_OFF_CTRL0, {1'b0, s[2:0], 4'h2});
            wr(`FRIT_OFF_CTRL1, 8'h80);
            rd(`FRIT_OFF_COUNT, a);
            chk("start_cnt", {7'h0, a <= 8'h01}, 8'h01);
            repeat ((4 << (s + 1)) - 2) @(posedge clk_i);
            rd(`FRIT_OFF_COUNT, b);
            chk("rate", b - a, 8'h04);
        end
        a = (rnd() & 8'h7f) | 8'h01;
        b = a + 8'h40;
        wr(`FRIT_OFF_CTRL1, 8'h00);
        wr(`FRIT_OFF_CTRL0, 8'h02);
        wr(`FRIT_OFF_OUTMODE, 8'h00);
        wr(`FRIT_OFF_CMP, a);
        wr(`FRIT_OFF_CTRL1, 8'ha0);
        wr(`FRIT_OFF_CMP, b);
        at_match(a, 1'b1);
        rd(`FRIT_OFF_CTRL1, v);
        chk("run_flag", v & 8'ha4, 8'ha4);
        wr(`FRIT_OFF_CTRL1, 8'h84);
        rd(`FRIT_OFF_CTRL1, v);
        chk("flag_kept", v & 8'h84, 8'h84);
        chk("irq_masked", {7'h0, irq_o}, 8'h00);
        wr(`FRIT_OFF_CTRL1, 8'ha0);
        rd(`FRIT_OFF_CTRL1, v);
        chk("flag_clr", {7'h0, v[2] | irq_o}, 8'h00);
        at_match(b, 1'b0);
        wr(`FRIT_OFF_CTRL1, 8'ha0);
        a = 8'h00;
        for (int i = 0; i < 300; i++) begin
            rd(`FRIT_OFF_COUNT, v);
            if (v < a) break;
            a = v;
        end
        chk("wrap", {7'h0, v < 8'h08}, 8'h01);
        at_match(b, 1'b1);
        wr(`FRIT_OFF_CTRL1, 8'h00);
        rd(`FRIT_OFF_COUNT, a);
        repeat (40) @(posedge clk_i);
        rd(`FRIT_OFF_COUNT, v);
        chk("stopped", v, a);
        chk("hold_level", {7'h0, lvl_o}, 8'h01);
        complete_run();
    end
endmodule : frit_timer_tb
